// File: core/idx_pkg.sv
// Constants shared by the indirect data addressing unit and its resolver
package idx_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int BANK_W = 4;
	localparam int PHYS_W = ADDR_W + BANK_W;
	localparam int APB_AW = 12;

	// Register byte offsets on the bus
	localparam logic [APB_AW-1:0] OFF_PTR0 = 12'h000;
	localparam logic [APB_AW-1:0] OFF_PTR1 = 12'h004;
	localparam logic [APB_AW-1:0] OFF_ALU = 12'h008;
	localparam logic [APB_AW-1:0] OFF_BSR = 12'h00c;

	// File addresses of the two indirect access ports
	localparam logic [ADDR_W-1:0] PORT0_ADDR = 8'h00;
	localparam logic [ADDR_W-1:0] PORT1_ADDR = 8'h08;

	// Banked regions of the file space
	localparam logic [ADDR_W-1:0] PERIPH_LO = 8'h10;
	localparam logic [ADDR_W-1:0] PERIPH_HI = 8'h17;
	localparam logic [ADDR_W-1:0] GPR_LO = 8'h20;

	// ALU status field positions
	localparam int P1_MODE_HI = 7;
	localparam int P1_MODE_LO = 6;
	localparam int P0_MODE_HI = 5;
	localparam int P0_MODE_LO = 4;
	localparam int Z_BIT = 2;
	localparam int FLAGS_HI = 3;

	// Reset values
	localparam logic [DATA_W-1:0] ALU_RST = 8'hf0;
	localparam logic [ADDR_W-1:0] PTR_RST = 8'h00;
	localparam logic [DATA_W-1:0] BSR_RST = 8'h00;

	// Pointer mode codes; any code with the upper bit set holds
	localparam logic [1:0] MODE_DEC = 2'b00;
	localparam logic [1:0] MODE_INC = 2'b01;

	typedef enum logic [1:0] {
		APB_IDLE = 2'b01,
		APB_ACCESS = 2'b10
	} apb_state_e;
endpackage

// File: core/ind_res_if.sv
// Carrier between the addressing unit and one address resolver
`timescale 1ns/1ps
interface ind_res_if;
	logic [idx_pkg::ADDR_W-1:0] file_addr;
	logic [idx_pkg::ADDR_W-1:0] ptr0;
	logic [idx_pkg::ADDR_W-1:0] ptr1;
	logic [idx_pkg::DATA_W-1:0] bank_select_register;
	logic [idx_pkg::PHYS_W-1:0] phys;
	logic via_port0;
	logic via_port1;
	logic null_ref;

	modport requester(
		output file_addr, ptr0, ptr1, bank_select_register,
		input phys, via_port0, via_port1, null_ref
	);
	modport resolver(
		input file_addr, ptr0, ptr1, bank_select_register,
		output phys, via_port0, via_port1, null_ref
	);
endinterface

// File: core/ind_resolver.sv
// Maps a file address, direct or through a port, to a physical index
`timescale 1ns/1ps
module ind_resolver (
	ind_res_if.resolver res
);
	import idx_pkg::*;

	logic [ADDR_W-1:0] eff;

	function automatic logic [PHYS_W-1:0] bank_map(
		input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] b
	);
		logic [BANK_W-1:0] bank;
		bank = '0;
		if (a >= PERIPH_LO && a <= PERIPH_HI) begin
			bank = b[BANK_W-1:0];
		end else if (a >= GPR_LO) begin
			bank = b[DATA_W-1:BANK_W];
		end
		return {bank, a};
	endfunction

	// Ports hold nothing: the pointer supplies the real address
	always_comb begin
		res.via_port0 = (res.file_addr == PORT0_ADDR);
		res.via_port1 = (res.file_addr == PORT1_ADDR);
		if (res.via_port0) begin
			eff = res.ptr0;
		end else if (res.via_port1) begin
			eff = res.ptr1;
		end else begin
			eff = res.file_addr;
		end
		// Zero pointer is port zero itself, so one test covers both
		res.null_ref = (res.via_port0 || res.via_port1) &&
			(eff == PORT0_ADDR || eff == PORT1_ADDR);
		res.phys = bank_map(eff, res.bank_select_register);
	end
endmodule

// File: core/ind_addr_unit.sv
// Indirect data addressing unit with pointers, banking and APB registers
//
// Overview of operation
// - Port access goes to pointer's addressed location
// - Pointers are eight bits, full range
// - Banked locations use bank select value
// - Read through port at port: zero, Z set
// - Write through port at port: nothing stored, pointer still steps
// - Each pointer post-modified after indirect access
// - Mode 00 decrement, 01 increment, 1x hold
// - Pointer one upper field, zero lower field
// - Pointer one bits 7-6, zero bits 5-4
// - Pointer updates never change status flags
// - Zero pointer: read zero, write nothing
// - Port moves finish in one cycle
`timescale 1ns/1ps
module ind_addr_unit #(
	parameter int MEM_DEPTH = 4096
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [idx_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rd_en,
	input wire logic [idx_pkg::ADDR_W-1:0] rd_addr,
	input wire logic wr_en,
	input wire logic [idx_pkg::ADDR_W-1:0] wr_addr,
	input wire logic [idx_pkg::DATA_W-1:0] wr_data,
	output logic [idx_pkg::DATA_W-1:0] rd_data,
	output logic rd_valid,
	output logic [idx_pkg::ADDR_W-1:0] pointer_zero,
	output logic [idx_pkg::ADDR_W-1:0] pointer_one,
	output logic [idx_pkg::DATA_W-1:0] alu_status_register
);
	import idx_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic [ADDR_W-1:0] ptr0_r;
	logic [ADDR_W-1:0] ptr1_r;
	logic [DATA_W-1:0] alu_r;
	logic [DATA_W-1:0] bsr_r;
	logic [DATA_W-1:0] rd_data_r;
	logic rd_valid_r;
	logic [31:0] prdata_r;
	logic err_r;
	apb_state_e state_r;
	apb_state_e state_nxt;
	logic [DATA_W-1:0] mem [MEM_DEPTH];

	logic apb_wr;
	logic apb_setup;
	logic map_hit;
	logic rd_null;
	logic wr_null;
	logic use0;
	logic use1;
	logic [ADDR_W-1:0] ptr0_nxt;
	logic [ADDR_W-1:0] ptr1_nxt;

	ind_res_if rd_res();
	ind_res_if wr_res();

	// Step a pointer by its two-bit mode, modulo 256, no flags
	function automatic logic [ADDR_W-1:0] step_ptr(
		input logic [ADDR_W-1:0] p,
		input logic [1:0] mode
	);
		logic [ADDR_W-1:0] q;
		q = p;
		if (mode == MODE_DEC) begin
			q = ADDR_W'(p - 1'b1);
		end else if (mode == MODE_INC) begin
			q = ADDR_W'(p + 1'b1);
		end
		return q;
	endfunction

	function automatic logic decode_hit(input logic [APB_AW-1:0] a);
		return a == OFF_PTR0 || a == OFF_PTR1 || a == OFF_ALU ||
			a == OFF_BSR;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Two resolvers so a port-to-port move reads and writes in one cycle
	assign rd_res.file_addr = rd_addr;
	assign rd_res.ptr0 = ptr0_r;
	assign rd_res.ptr1 = ptr1_r;
	assign rd_res.bank_select_register = bsr_r;
	assign wr_res.file_addr = wr_addr;
	assign wr_res.ptr0 = ptr0_r;
	assign wr_res.ptr1 = ptr1_r;
	assign wr_res.bank_select_register = bsr_r;

	ind_resolver u_rd_res (
		.res(rd_res.resolver)
	);
	ind_resolver u_wr_res (
		.res(wr_res.resolver)
	);

	assign rd_null = rd_en && rd_res.null_ref;
	assign wr_null = wr_en && wr_res.null_ref;
	// A move through the same port twice still steps once
	assign use0 = (rd_en && rd_res.via_port0) ||
		(wr_en && wr_res.via_port0);
	assign use1 = (rd_en && rd_res.via_port1) ||
		(wr_en && wr_res.via_port1);

	always_comb begin
		ptr0_nxt = step_ptr(ptr0_r, alu_r[P0_MODE_HI:P0_MODE_LO]);
		ptr1_nxt = step_ptr(ptr1_r, alu_r[P1_MODE_HI:P1_MODE_LO]);
	end

	////////////////////////////////////////////////////////////////////////
	// APB slave
	assign apb_setup = psel && !penable;
	assign apb_wr = psel && penable && pwrite && pready;
	assign map_hit = decode_hit(paddr);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			APB_IDLE: begin
				if (apb_setup) begin
					state_nxt = APB_ACCESS;
				end
			end
			APB_ACCESS: begin
				state_nxt = APB_IDLE;
			end
			default: begin
				state_nxt = APB_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= APB_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Read data is captured in setup so it comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
			err_r <= 1'b0;
		end else if (apb_setup) begin
			err_r <= !map_hit;
			unique case (paddr)
				OFF_PTR0: prdata_r <= {24'h00_0000, ptr0_r};
				OFF_PTR1: prdata_r <= {24'h00_0000, ptr1_r};
				OFF_ALU: prdata_r <= {24'h00_0000, alu_r};
				OFF_BSR: prdata_r <= {24'h00_0000, bsr_r};
				default: prdata_r <= 32'h0000_0000;
			endcase
		end
	end

	assign pready = (state_r == APB_ACCESS);
	assign prdata = prdata_r;
	assign pslverr = pready && err_r;

	////////////////////////////////////////////////////////////////////////
	// Pointers: software write wins over an auto step in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr0_r <= PTR_RST;
		end else if (apb_wr && paddr == OFF_PTR0 && pstrb[0]) begin
			ptr0_r <= pwdata[ADDR_W-1:0];
		end else if (use0) begin
			ptr0_r <= ptr0_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr1_r <= PTR_RST;
		end else if (apb_wr && paddr == OFF_PTR1 && pstrb[0]) begin
			ptr1_r <= pwdata[ADDR_W-1:0];
		end else if (use1) begin
			ptr1_r <= ptr1_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bsr_r <= BSR_RST;
		end else if (apb_wr && paddr == OFF_BSR && pstrb[0]) begin
			bsr_r <= pwdata[DATA_W-1:0];
		end
	end

	// Status: only a null read touches a flag; set beats clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alu_r <= ALU_RST;
		end else begin
			if (apb_wr && paddr == OFF_ALU && pstrb[0]) begin
				alu_r <= pwdata[DATA_W-1:0];
			end
			if (rd_null) begin
				alu_r[Z_BIT] <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Data memory
	always_ff @(posedge pclk) begin
		if (wr_en && !wr_null) begin
			mem[wr_res.phys] <= wr_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_data_r <= 8'h00;
			rd_valid_r <= 1'b0;
		end else begin
			rd_valid_r <= rd_en;
			if (rd_null) begin
				rd_data_r <= 8'h00;
			end else if (rd_en) begin
				rd_data_r <= mem[rd_res.phys];
			end
		end
	end

	assign rd_data = rd_data_r;
	assign rd_valid = rd_valid_r;
	assign pointer_zero = ptr0_r;
	assign pointer_one = ptr1_r;
	assign alu_status_register = alu_r;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic ptr0_sw;
	logic ptr1_sw;
	logic alu_sw;
	assign ptr0_sw = apb_wr && paddr == OFF_PTR0;
	assign ptr1_sw = apb_wr && paddr == OFF_PTR1;
	assign alu_sw = apb_wr && paddr == OFF_ALU;
	logic [ADDR_W-1:0] wd_lo;
	assign wd_lo = pwdata[ADDR_W-1:0];

	AST_NULL_READ_ZERO: assert property (
		rd_null |=> rd_data == 8'h00 && rd_valid
	) else $error("null read did not return zero");

	AST_NULL_READ_ZFLAG: assert property (
		rd_null |=> alu_status_register[Z_BIT]
	) else $error("null read did not set zero flag");

	AST_NULL_WRITE_NOP: assert property (
		wr_null && !rd_en && !alu_sw |=> $stable(alu_status_register)
	) else $error("null write changed status");

	AST_PTR0_INC: assert property (
		use0 && !ptr0_sw && alu_r[P0_MODE_HI:P0_MODE_LO] == MODE_INC
		|=> pointer_zero == ADDR_W'($past(pointer_zero) + 1'b1)
	) else $error("pointer zero did not increment");

	AST_PTR1_DEC: assert property (
		use1 && !ptr1_sw && alu_r[P1_MODE_HI:P1_MODE_LO] == MODE_DEC
		|=> pointer_one == ADDR_W'($past(pointer_one) - 1'b1)
	) else $error("pointer one did not decrement");

	AST_PTR_HOLD: assert property (
		alu_r[P1_MODE_HI] && alu_r[P0_MODE_HI] && !apb_wr
		|=> $stable(pointer_zero) && $stable(pointer_one)
	) else $error("pointer moved in hold mode");

	AST_FLAGS_UNTOUCHED: assert property (
		(use0 || use1) && !rd_null && !alu_sw
		|=> $stable(alu_status_register[FLAGS_HI:0])
	) else $error("pointer step changed a flag");

	AST_WRAP_INC: assert property (
		use0 && !ptr0_sw && pointer_zero == 8'hff &&
		alu_r[P0_MODE_HI:P0_MODE_LO] == MODE_INC |=> pointer_zero == 8'h00
	) else $error("pointer zero did not wrap");

	AST_BANK_PERIPH: assert property (
		rd_en && rd_addr >= PERIPH_LO && rd_addr <= PERIPH_HI
		|-> rd_res.phys[PHYS_W-1:ADDR_W] == bsr_r[BANK_W-1:0]
	) else $error("peripheral bank not from bank select");

	AST_READ_ONE_CYCLE: assert property (
		rd_en |=> rd_valid ##1 (rd_valid == $past(rd_en))
	) else $error("read did not answer in one cycle");

	AST_APB_ONE_WAIT: assert property (
		apb_setup |=> pready ##1 !pready
	) else $error("apb answer timing wrong");

	AST_PTR0_DEC: assert property (
		use0 && !ptr0_sw && alu_r[P0_MODE_HI:P0_MODE_LO] == MODE_DEC
		|=> pointer_zero == ADDR_W'($past(pointer_zero) - 1'b1)
	) else $error("pointer zero did not decrement");

	AST_PTR1_INC: assert property (
		use1 && !ptr1_sw && alu_r[P1_MODE_HI:P1_MODE_LO] == MODE_INC
		|=> pointer_one == ADDR_W'($past(pointer_one) + 1'b1)
	) else $error("pointer one did not increment");

	AST_WRAP_DEC: assert property (
		use1 && !ptr1_sw && pointer_one == 8'h00 &&
		alu_r[P1_MODE_HI:P1_MODE_LO] == MODE_DEC |=> pointer_one == 8'hff
	) else $error("pointer one did not wrap");

	AST_BANK_GPR: assert property (
		rd_en && rd_addr >= GPR_LO
		|-> rd_res.phys[PHYS_W-1:ADDR_W] == bsr_r[DATA_W-1:BANK_W]
	) else $error("memory bank not from bank select");

	AST_PTR0_IDLE: assert property (
		!use0 && !ptr0_sw
		|=> $stable(pointer_zero)
	) else $error("pointer zero moved without an access");

	AST_PTR0_LOAD: assert property (
		ptr0_sw && pstrb[0]
		|=> pointer_zero == $past(wd_lo)
	) else $error("pointer zero write did not land");

	COV_PORT_MOVE: cover property (
		rd_en && rd_res.via_port0 && wr_en && wr_res.via_port1
	);
	COV_NULL_READ: cover property (rd_null);
	COV_NULL_WRITE: cover property (wr_null);
	COV_WRAP_DEC: cover property (
		use1 && pointer_one == 8'h00 &&
		alu_r[P1_MODE_HI:P1_MODE_LO] == MODE_DEC
	);
endmodule

// File: dv/core_port_model.sv
// Core-side model issuing file reads and writes to the unit
`timescale 1ns/1ps
module core_port_model (
	input wire logic pclk,
	output logic rd_en,
	output logic [7:0] rd_addr,
	output logic wr_en,
	output logic [7:0] wr_addr,
	output logic [7:0] wr_data,
	input wire logic [7:0] rd_data,
	input wire logic rd_valid
);
	initial begin
		rd_en = 1'b0;
		wr_en = 1'b0;
		rd_addr = 8'h00;
		wr_addr = 8'h00;
		wr_data = 8'h00;
	end

	// Read and write at one edge form a port-to-port move
	task automatic access(input logic rd, input logic [7:0] ra,
		input logic wr, input logic [7:0] wa, input logic [7:0] wd,
		output logic v, output logic [7:0] d);
		@(posedge pclk);
		rd_en <= rd;
		rd_addr <= ra;
		wr_en <= wr;
		wr_addr <= wa;
		wr_data <= wd;
		@(posedge pclk);
		rd_en <= 1'b0;
		wr_en <= 1'b0;
		// Stale data must not look valid once released
		wr_data <= ~wd;
		// The answer stands one cycle; take it at the next edge
		@(posedge pclk);
		v = rd_valid;
		d = rd_data;
	endtask
endmodule

// File: dv/indirect_data_addressing_bench.sv
// Self-checking bench for the indirect data addressing unit
`timescale 1ns/1ps
module indirect_data_addressing_bench;
	import idx_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite;
	logic [APB_AW-1:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic pready, pslverr, rd_en, wr_en, rd_valid;
	logic [7:0] rd_addr, wr_addr, wr_data, rd_data;
	logic [7:0] pointer_zero, pointer_one, alu_status_register;
	int n_mismatch = 0;
	int compares = 0;
	logic [31:0] rv;
	logic e, v;
	logic [7:0] d;
	logic [7:0] st[4] = '{8'h40, 8'hff, 8'h40, 8'h40};
	logic [7:0] nx[4] = '{8'h3f, 8'h00, 8'h40, 8'h40};

	always #4 pclk = ~pclk;

	ind_addr_unit u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .rd_en, .rd_addr,
		.wr_en, .wr_addr, .wr_data, .rd_data, .rd_valid, .pointer_zero,
		.pointer_one, .alu_status_register);
	core_port_model u_core (.pclk, .rd_en, .rd_addr, .wr_en, .wr_addr,
		.wr_data, .rd_data, .rd_valid);

	////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] x,
		input logic [31:0] g);
		compares++;
		if (g !== x) begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", n, x, g);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [7:0] wd);
		int i;
		logic done;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		done = 1'b0;
		// Answer taken at the very edge that samples pready high
		for (i = 0; i < 16 && !done; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) begin
				rv = prdata;
				e = pslverr;
				done = 1'b1;
			end
		end
		if (!done) begin
			n_mismatch++;
			close_out();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rr(input string n, input logic [11:0] a,
		input logic [7:0] x);
		apb(1'b0, a, 8'h00);
		chk(n, {24'h0, x}, rv);
	endtask

	task automatic mv(input logic r, input logic [7:0] ra, input logic w,
		input logic [7:0] wa, input logic [7:0] wd);
		u_core.access(r, ra, w, wa, wd, v, d);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'h1;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rr("ptr0", OFF_PTR0, PTR_RST);
		rr("ptr1", OFF_PTR1, PTR_RST);
		rr("alu", OFF_ALU, ALU_RST);
		rr("bsr", OFF_BSR, BSR_RST);
		apb(1'b0, 12'h010, 8'h00);
		chk("slverr", 32'h1, {31'h0, e});
		chk("unmapped", 32'h0, rv);
		// Every pointer-zero mode, including the wrap at ff
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, OFF_PTR0, st[k]);
			apb(1'b1, OFF_PTR1, 8'h60);
			apb(1'b1, OFF_ALU, {2'b10, k[1:0], 4'h0});
			mv(1'b0, 8'h00, 1'b1, PORT0_ADDR, 8'h11);
			rr("ptr0", OFF_PTR0, nx[k]);
			chk("pointer_zero", {24'h0, nx[k]}, {24'h0, pointer_zero});
			rr("ptr1", OFF_PTR1, 8'h60);
			rr("alu", OFF_ALU, {2'b10, k[1:0], 4'h0});
		end
		apb(1'b1, OFF_PTR0, 8'h33);
		apb(1'b1, OFF_PTR1, 8'h7f);
		apb(1'b1, OFF_ALU, 8'h60);
		mv(1'b0, 8'h00, 1'b1, PORT1_ADDR, 8'h22);
		chk("rd_valid", 32'h0, {31'h0, v});
		rr("ptr1", OFF_PTR1, 8'h80);
		rr("ptr0", OFF_PTR0, 8'h33);
		// Indirect read lands on the pointed location
		mv(1'b0, 8'h00, 1'b1, 8'h20, 8'ha5);
		apb(1'b1, OFF_PTR0, 8'h20);
		apb(1'b1, OFF_ALU, 8'h90);
		mv(1'b1, PORT0_ADDR, 1'b0, 8'h00, 8'h00);
		chk("rd_valid", 32'h1, {31'h0, v});
		chk("rd_data", 32'ha5, {24'h0, d});
		rr("ptr0", OFF_PTR0, 8'h21);
		// Pointer aimed at the other port, then at zero
		apb(1'b1, OFF_PTR0, PORT1_ADDR);
		apb(1'b1, OFF_ALU, 8'hf0);
		mv(1'b1, PORT0_ADDR, 1'b0, 8'h00, 8'h00);
		chk("rd_data", 32'h0, {24'h0, d});
		rr("alu", OFF_ALU, 8'hf4);
		chk("alu_status_register", 32'hf4, {24'h0, alu_status_register});
		apb(1'b1, OFF_ALU, 8'hf0);
		apb(1'b1, OFF_PTR1, 8'h00);
		mv(1'b1, PORT1_ADDR, 1'b0, 8'h00, 8'h00);
		chk("rd_data", 32'h0, {24'h0, d});
		rr("alu", OFF_ALU, 8'hf4);
		apb(1'b1, OFF_ALU, 8'hf0);
		apb(1'b1, OFF_PTR0, 8'h00);
		mv(1'b0, 8'h00, 1'b1, PORT0_ADDR, 8'h5a);
		rr("alu", OFF_ALU, 8'hf0);
		// Same offset in two general-purpose banks
		mv(1'b0, 8'h00, 1'b1, 8'h30, 8'hc3);
		apb(1'b1, OFF_BSR, 8'h20);
		apb(1'b1, OFF_PTR0, 8'h30);
		mv(1'b0, 8'h00, 1'b1, PORT0_ADDR, 8'h3c);
		mv(1'b1, PORT0_ADDR, 1'b0, 8'h00, 8'h00);
		chk("bank2", 32'h3c, {24'h0, d});
		apb(1'b1, OFF_BSR, 8'h00);
		mv(1'b1, 8'h30, 1'b0, 8'h00, 8'h00);
		chk("bank0", 32'hc3, {24'h0, d});
		// Port-to-port move in one access
		apb(1'b1, OFF_PTR0, 8'h20);
		apb(1'b1, OFF_PTR1, 8'h50);
		apb(1'b1, OFF_ALU, 8'h50);
		mv(1'b1, PORT0_ADDR, 1'b1, PORT1_ADDR, 8'h77);
		chk("move_src", 32'ha5, {24'h0, d});
		rr("ptr0", OFF_PTR0, 8'h21);
		rr("ptr1", OFF_PTR1, 8'h51);
		chk("pointer_one", 32'h51, {24'h0, pointer_one});
		mv(1'b1, 8'h50, 1'b0, 8'h00, 8'h00);
		chk("move_dst", 32'h77, {24'h0, d});
		// Pointer one stepping down through zero on a null write
		apb(1'b1, OFF_PTR1, 8'h00);
		apb(1'b1, OFF_ALU, 8'h30);
		mv(1'b0, 8'h00, 1'b1, PORT1_ADDR, 8'h99);
		rr("ptr1", OFF_PTR1, 8'hff);
		rr("alu", OFF_ALU, 8'h30);
		close_out();
	end
endmodule
